// >>> rtl/ccm_pkg.sv
package ccm_pkg;

	// Register byte offsets
	localparam logic [7:0] MODE_OFFSET   = 8'h18;
	localparam logic [7:0] CH1_CMP_OFFSET = 8'h34;
	localparam logic [7:0] CH2_CMP_OFFSET = 8'h38;
	localparam logic [7:0] STATUS_OFFSET  = 8'h40;
	localparam logic [31:0] MODE_RESET    = 32'h0000_0000;

	// Field positions inside the mode register, per channel (ch1 at 0)
	localparam int CH_STRIDE   = 8;
	localparam int SEL_LSB     = 0;
	localparam int PSC_LSB     = 2;
	localparam int FILT_LSB    = 4;
	localparam int FAST_BIT    = 2;
	localparam int BUF_BIT     = 3;
	localparam int OCM_LSB     = 4;

	// Status register field positions
	localparam int ST_CAP_LSB  = 0;
	localparam int ST_FILT_LSB = 2;
	localparam int ST_REF_LSB  = 4;

	// Peripheral clock derivation from the 100 MHz system clock
	localparam int MCLK_MHZ      = 100;
	localparam int PCLK_XTAL_MHZ = 12;
	localparam int PCLK_RC_MHZ   = 6;

	localparam int CNT_W = 16;

	typedef enum logic [1:0] {
		SEL_OUTPUT  = 2'b00,
		SEL_OWN_PIN = 2'b01,
		SEL_X_PIN   = 2'b10,
		SEL_TRIGGER = 2'b11
	} ccm_sel_t;

	typedef enum logic [2:0] {
		OCM_FROZEN   = 3'b000,
		OCM_SET      = 3'b001,
		OCM_CLEAR    = 3'b010,
		OCM_TOGGLE   = 3'b011,
		OCM_FORCE_LO = 3'b100,
		OCM_FORCE_HI = 3'b101,
		OCM_PWM1     = 3'b110,
		OCM_PWM2     = 3'b111
	} ccm_ocm_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} ccm_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} ccm_apb_rsp_t;

endpackage : ccm_pkg

// >>> rtl/ccm_channel_mode.sv
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ps
// How it works
// - Selection zero makes a compare output; nonzero makes a capture input.
// - Channel two selection 01 own pin, 10 pin one, 11 trigger.
// - Channel one selection 01 own pin, 10 pin two, 11 trigger.
// - Filter output changes after N equal consecutive samples.
// - Code 0000 no filtering, 0001 needs two samples, both at PCLK.
// - Code 0010 samples at PCLK and needs eight samples.
// - Codes 1010-1100 sample at PCLK/16, needing 5, 6, 8.
// - Codes 1101-1111 sample at PCLK/32, needing 5, 6, 8.
// - Code 1001 samples at PCLK/8 and needs eight samples.
// - Code 0110 samples at PCLK/4 and needs eight samples.
// - PCLK is 12 MHz on crystal, 6 MHz on RC oscillator.
// - Prescaler captures every 1st, 2nd, 4th or 8th edge.
// - Channel two fields at 15:12, 11:10, 9:8; channel one 7:4, 3:2, 1:0.
// - Channel one compare mode 6:4, buffer 3, fast 2, like channel two.
// - Compare modes frozen, set, clear, toggle, force low/high, PWM1, PWM2.
// - Buffered compare writes load the active value at update event.
// - Fast enable in PWM makes a trigger edge act as match.
module ccm_channel_mode #(
	parameter int CNT_W = ccm_pkg::CNT_W
) (
	input  wire logic                 mclk,
	input  wire logic                 reset_n,
	input  wire ccm_pkg::ccm_apb_req_t apb_req,
	output ccm_pkg::ccm_apb_rsp_t      apb_rsp,
	input  wire logic                 timer_input_one,
	input  wire logic                 timer_input_two,
	input  wire logic                 internal_trigger_input,
	input  wire logic                 clock_from_rc_osc,
	input  wire logic                 update_event,
	input  wire logic [CNT_W-1:0]     timer_counter_value,
	output logic [1:0]                ch_output_reference,
	output logic [1:0]                ch_capture_pulse,
	output logic [1:0]                ch_filtered_level
);

	typedef struct packed {
		logic [31:0]            mode;
		logic [1:0][CNT_W-1:0]  cmp_buf;
		logic [1:0][CNT_W-1:0]  cmp_act;
		logic [1:0][CNT_W-1:0]  cap_val;
		logic [2:0]             sync1;
		logic [2:0]             sync2;
		logic [6:0]             pacc;
		logic [4:0]             div_cnt;
		logic [1:0][2:0]        fcnt;
		logic [1:0]             filt;
		logic [1:0]             filt_prev;
		logic [1:0][2:0]        pcnt;
		logic [1:0]             cap_flag;
		logic [1:0]             cap_pulse;
		logic [1:0]             oref;
		logic                   trig_prev;
		logic [31:0]            prdata;
	} ccm_state_t;

	ccm_state_t s_q;
	ccm_state_t s_d;

	// Filter code to {log2 of rate divider, sample count}
	function automatic logic [6:0] ccm_filter_decode(input logic [3:0] code);
		logic [6:0] r;
		r = 7'h00;
		case (code)
			4'h0: r = {3'h0, 4'h1};
			4'h1: r = {3'h0, 4'h2};
			4'h2: r = {3'h0, 4'h8};
			4'h3: r = {3'h1, 4'h6};
			4'h4: r = {3'h1, 4'h8};
			4'h5: r = {3'h2, 4'h6};
			4'h6: r = {3'h2, 4'h8};
			4'h7: r = {3'h3, 4'h5};
			4'h8: r = {3'h3, 4'h6};
			4'h9: r = {3'h3, 4'h8};
			4'ha: r = {3'h4, 4'h5};
			4'hb: r = {3'h4, 4'h6};
			4'hc: r = {3'h4, 4'h8};
			4'hd: r = {3'h5, 4'h5};
			4'he: r = {3'h5, 4'h6};
			4'hf: r = {3'h5, 4'h8};
			default: r = 7'h00;
		endcase
		return r;
	endfunction : ccm_filter_decode

	// Field extraction shared by both channels
	function automatic logic [7:0] ccm_ch_byte(input logic [31:0] m,
	                                           input int ch);
		return m[ch*ccm_pkg::CH_STRIDE +: 8];
	endfunction : ccm_ch_byte

	logic       pclk_tick;
	logic [6:0] pclk_step;
	logic       bus_setup;
	logic       bus_write;
	logic       addr_hit;

	assign bus_setup = apb_req.psel && !apb_req.penable;
	assign bus_write = apb_req.psel && apb_req.penable && apb_req.pwrite;
	assign addr_hit  = (apb_req.paddr == ccm_pkg::MODE_OFFSET) ||
	                   (apb_req.paddr == ccm_pkg::CH1_CMP_OFFSET) ||
	                   (apb_req.paddr == ccm_pkg::CH2_CMP_OFFSET) ||
	                   (apb_req.paddr == ccm_pkg::STATUS_OFFSET);

	// Zero-wait slave; unmapped addresses answer with an error
	assign apb_rsp.pready  = 1'b1;
	assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !addr_hit;
	assign apb_rsp.prdata  = s_q.prdata;

	// PCLK as an average-rate tick: the fraction hides the 100/12 ratio
	assign pclk_step = s_q.sync2[2] ? 7'(ccm_pkg::PCLK_RC_MHZ)
	                                : 7'(ccm_pkg::PCLK_XTAL_MHZ);
	assign pclk_tick = (7'(s_q.pacc + pclk_step) >=
	                    7'(ccm_pkg::MCLK_MHZ));

	assign ch_output_reference = s_q.oref;
	assign ch_capture_pulse    = s_q.cap_pulse;
	assign ch_filtered_level   = s_q.filt;

	// Next-state logic for the whole block
	always_comb begin
		logic [7:0]       cb;
		logic [1:0]       sel;
		logic [6:0]       fd;
		logic [4:0]       mask;
		logic             samp_en;
		logic             src;
		logic             rise;
		logic             match;
		logic             less;
		logic             trig_edge;
		logic [2:0]       psc_top;
		logic [CNT_W-1:0] wval;
		cb        = 8'h00;
		sel       = 2'h0;
		fd        = 7'h00;
		mask      = 5'h00;
		samp_en   = 1'b0;
		src       = 1'b0;
		rise      = 1'b0;
		match     = 1'b0;
		less      = 1'b0;
		psc_top   = 3'h0;
		wval      = pwdata_cnt(apb_req.pwdata);
		trig_edge = internal_trigger_input && !s_q.trig_prev;
		s_d       = s_q;

		// Pins pass two flops; the first is read only by the second
		s_d.sync1 = {clock_from_rc_osc, timer_input_two, timer_input_one};
		s_d.sync2 = s_q.sync1;
		s_d.trig_prev = internal_trigger_input;

		// Peripheral clock accumulator and sample-rate divider
		if (pclk_tick) begin
			s_d.pacc    = 7'(s_q.pacc + pclk_step - 7'(ccm_pkg::MCLK_MHZ));
			s_d.div_cnt = 5'(s_q.div_cnt + 5'h01);
		end else begin
			s_d.pacc = 7'(s_q.pacc + pclk_step);
		end

		// Register writes take effect at the access-phase edge
		if (bus_write) begin
			if (apb_req.paddr == ccm_pkg::MODE_OFFSET) begin
				s_d.mode = {16'h0000, apb_req.pwdata[15], apb_req.pwdata[14:8],
				            apb_req.pwdata[7], apb_req.pwdata[6:0]};
			end else if (apb_req.paddr == ccm_pkg::STATUS_OFFSET) begin
				s_d.cap_flag = s_q.cap_flag &
				               ~apb_req.pwdata[ccm_pkg::ST_CAP_LSB +: 2];
			end
		end

		for (int ch = 0; ch < 2; ch++) begin
			cb  = ccm_ch_byte(s_q.mode, ch);
			sel = cb[ccm_pkg::SEL_LSB +: 2];
			fd  = ccm_filter_decode(cb[ccm_pkg::FILT_LSB +: 4]);
			mask = 5'((6'h01 << fd[6:4]) - 6'h01);
			samp_en = pclk_tick && ((s_q.div_cnt & mask) == mask);

			// Input source routing per channel
			case (sel)
				ccm_pkg::SEL_OWN_PIN: src = s_q.sync2[ch];
				ccm_pkg::SEL_X_PIN:   src = s_q.sync2[1 - ch];
				ccm_pkg::SEL_TRIGGER: src = internal_trigger_input;
				default:              src = s_q.filt[ch];
			endcase

			// Digital filter: count samples that differ from the output
			if (samp_en && sel != ccm_pkg::SEL_OUTPUT) begin
				if (src == s_q.filt[ch]) begin
					s_d.fcnt[ch] = 3'h0;
				end else if (4'(s_q.fcnt[ch]) + 4'h1 >= fd[3:0]) begin
					s_d.filt[ch] = src;
					s_d.fcnt[ch] = 3'h0;
				end else begin
					s_d.fcnt[ch] = 3'(s_q.fcnt[ch] + 3'h1);
				end
			end
			s_d.filt_prev[ch] = s_q.filt[ch];

			// Edge prescaler and capture; 2^psc events per capture
			rise = s_q.filt[ch] && !s_q.filt_prev[ch];
			psc_top = 3'((4'h1 << cb[ccm_pkg::PSC_LSB +: 2]) - 4'h1);
			s_d.cap_pulse[ch] = 1'b0;
			if (sel != ccm_pkg::SEL_OUTPUT && rise) begin
				if (s_q.pcnt[ch] >= psc_top) begin
					s_d.pcnt[ch]      = 3'h0;
					s_d.cap_pulse[ch] = 1'b1;
					s_d.cap_val[ch]   = timer_counter_value;
					s_d.cap_flag[ch]  = 1'b1;
				end else begin
					s_d.pcnt[ch] = 3'(s_q.pcnt[ch] + 3'h1);
				end
			end

			// Compare value write and buffered load on update event
			if (bus_write && apb_req.paddr == (ch == 0 ?
			    ccm_pkg::CH1_CMP_OFFSET : ccm_pkg::CH2_CMP_OFFSET)) begin
				s_d.cmp_buf[ch] = wval;
				if (!cb[ccm_pkg::BUF_BIT]) begin
					s_d.cmp_act[ch] = wval;
				end
			end
			if (update_event && cb[ccm_pkg::BUF_BIT]) begin
				s_d.cmp_act[ch] = s_q.cmp_buf[ch];
			end

			// Output reference generation, only for compare outputs
			match = (timer_counter_value == s_q.cmp_act[ch]);
			less  = (timer_counter_value <  s_q.cmp_act[ch]);
			if (sel != ccm_pkg::SEL_OUTPUT) begin
				s_d.oref[ch] = 1'b0;
			end else begin
				case (ccm_pkg::ccm_ocm_t'(cb[ccm_pkg::OCM_LSB +: 3]))
					ccm_pkg::OCM_FROZEN:   s_d.oref[ch] = s_q.oref[ch];
					ccm_pkg::OCM_SET:      s_d.oref[ch] = s_q.oref[ch] | match;
					ccm_pkg::OCM_CLEAR:    s_d.oref[ch] = s_q.oref[ch] & ~match;
					ccm_pkg::OCM_TOGGLE:   s_d.oref[ch] = s_q.oref[ch] ^ match;
					ccm_pkg::OCM_FORCE_LO: s_d.oref[ch] = 1'b0;
					ccm_pkg::OCM_FORCE_HI: s_d.oref[ch] = 1'b1;
					ccm_pkg::OCM_PWM1:     s_d.oref[ch] = less;
					default:               s_d.oref[ch] = ~less;
				endcase
				// A trigger edge in PWM acts as a match without comparing
				if (cb[ccm_pkg::FAST_BIT] && cb[6] && cb[5] && trig_edge) begin
					s_d.oref[ch] = ~cb[4] ? 1'b0 : 1'b1;
				end
			end
		end

		// Read data is latched in the setup phase, so it comes from a flop
		if (bus_setup && !apb_req.pwrite) begin
			if (apb_req.paddr == ccm_pkg::MODE_OFFSET) begin
				s_d.prdata = s_q.mode;
			end else if (apb_req.paddr == ccm_pkg::CH1_CMP_OFFSET) begin
				s_d.prdata = 32'(rd_cmp(s_q.mode[1:0], s_q.cmp_buf[0],
				                        s_q.cap_val[0]));
			end else if (apb_req.paddr == ccm_pkg::CH2_CMP_OFFSET) begin
				s_d.prdata = 32'(rd_cmp(s_q.mode[9:8], s_q.cmp_buf[1],
				                        s_q.cap_val[1]));
			end else if (apb_req.paddr == ccm_pkg::STATUS_OFFSET) begin
				s_d.prdata = {26'h0, s_q.oref, s_q.filt, s_q.cap_flag};
			end else begin
				s_d.prdata = 32'h0000_0000;
			end
		end

		// A capture in the clearing cycle keeps its flag set
		for (int ch = 0; ch < 2; ch++) begin
			if (s_d.cap_pulse[ch]) begin
				s_d.cap_flag[ch] = 1'b1;
			end
		end
	end

	// Compare offset shows the buffer for outputs, the capture for inputs
	function automatic logic [CNT_W-1:0] rd_cmp(input logic [1:0] sel,
	                                            input logic [CNT_W-1:0] buf_v,
	                                            input logic [CNT_W-1:0] cap_v);
		return (sel == ccm_pkg::SEL_OUTPUT) ? buf_v : cap_v;
	endfunction : rd_cmp

	function automatic logic [CNT_W-1:0] pwdata_cnt(input logic [31:0] d);
		return d[CNT_W-1:0];
	endfunction : pwdata_cnt

	// Single state register; everything resets to zero
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

endmodule : ccm_channel_mode

// >>> verification/ccm_channel_mode_assertions.sv
`timescale 1ns/1ps
module ccm_channel_mode_assertions (
	input wire logic                  mclk,
	input wire logic                  reset_n,
	input wire ccm_pkg::ccm_apb_req_t apb_req,
	input wire ccm_pkg::ccm_apb_rsp_t apb_rsp,
	input wire logic [1:0]            ch_output_reference,
	input wire logic [1:0]            ch_capture_pulse,
	input wire logic [1:0]            ch_filtered_level
);
	logic        acc;
	logic        hit;
	logic [15:0] mode_q;
	// Access phase and address decode seen from the bus
	assign acc = apb_req.psel && apb_req.penable;
	assign hit = apb_req.paddr inside {8'h18, 8'h34, 8'h38, 8'h40};
	// Shadow of the mode word, so checks follow what software set
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			mode_q <= 16'h0000;
		end else if (acc && apb_req.pwrite && apb_rsp.pready
			&& apb_req.paddr == ccm_pkg::MODE_OFFSET) begin
			mode_q <= apb_req.pwdata[15:0];
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	AST_READY: assert property (acc |-> apb_rsp.pready)
		else $error("access phase without ready");
	AST_UNMAPPED: assert property (acc && !hit |-> apb_rsp.pslverr)
		else $error("unmapped access without error");
	AST_MAPPED: assert property (acc && hit |-> !apb_rsp.pslverr)
		else $error("mapped access flagged as error");
	AST_CAP_RISE: assert property (ch_capture_pulse[0] |->
		$past(ch_filtered_level[0]) && !$past(ch_filtered_level[0], 2))
		else $error("capture without filtered rising edge");
	AST_REF_IN_CAP: assert property ((mode_q[1:0] != 2'b00)[*2]
		|-> !ch_output_reference[0])
		else $error("reference active in capture mode");
	AST_FILT_FROZEN: assert property ((mode_q[9:8] == 2'b00)[*2]
		|-> $stable(ch_filtered_level[1]))
		else $error("filter moved in output mode");
	AST_FORCE_LO: assert property ((mode_q[1:0] == 2'b00
		&& mode_q[6:4] == 3'b100)[*2] |-> !ch_output_reference[0])
		else $error("forced low reference is high");
	AST_FORCE_HI: assert property ((mode_q[9:8] == 2'b00
		&& mode_q[14:12] == 3'b101)[*2] |-> ch_output_reference[1])
		else $error("forced high reference is low");
	// Main scenarios reached
	cover property (ch_capture_pulse[1]);
	cover property ($rose(ch_output_reference[0]));
	cover property (acc && apb_rsp.pslverr);
endmodule : ccm_channel_mode_assertions

// >>> verification/ccm_pins_model.sv
`timescale 1ns/1ps
module ccm_pins_model (
	input  wire logic mclk,
	output logic      pin_one,
	output logic      pin_two,
	output logic      trig
);
	logic [2:0] lv = 3'b000;
	// Trigger source is taken as already chosen upstream
	assign {trig, pin_two, pin_one} = lv;
	// Long low tail lets the slowest filter settle, and the channel
	// is quiet whenever software reprograms it
	task automatic pulse(input int src, input int hi);
		@(posedge mclk);
		lv[src] <= 1'b1;
		repeat (hi) @(posedge mclk);
		lv[src] <= 1'b0;
		repeat (2 * hi + 200) @(posedge mclk);
	endtask : pulse
endmodule : ccm_pins_model

// >>> verification/capture_compare_channel_mode_tb_top.sv
`timescale 1ns/1ps
module capture_compare_channel_mode_tb_top;
	typedef struct packed {
		logic [7:0]  a;
		logic [31:0] d;
		logic [31:0] q;
		logic        e;
	} ccm_row_t;
	localparam logic [7:0] MD = ccm_pkg::MODE_OFFSET;
	localparam logic [7:0] C1 = ccm_pkg::CH1_CMP_OFFSET;
	logic                  mclk;
	logic                  reset_n = 1'b0;
	ccm_pkg::ccm_apb_req_t req = '0;
	ccm_pkg::ccm_apb_rsp_t rsp;
	logic                  p1, p2, trg;
	logic                  rc = 1'b0;
	logic                  upd = 1'b0;
	logic [15:0]           ctr = 16'h0000;
	logic [1:0]            oref, capp, filt;
	logic [31:0]           rd;
	logic                  er;
	int                    bad_count = 0;
	int                    cmp_count = 0;
	int                    c0 = 0;
	int                    c1 = 0;
	ccm_row_t rows [5] = '{
		'{8'h18, 32'hffff_ffff, 32'h0000_ffff, 1'b0},
		'{8'h18, 32'h0000_1234, 32'h0000_1234, 1'b0},
		'{8'h34, 32'h0001_abcd, 32'h0000_abcd, 1'b0},
		'{8'h3c, 32'h0000_0005, 32'h0000_0000, 1'b1},
		'{8'h00, 32'h0000_0005, 32'h0000_0000, 1'b1}};
	ccm_channel_mode u_ccm_channel_mode (.mclk(mclk), .reset_n(reset_n),
		.apb_req(req), .apb_rsp(rsp), .timer_input_one(p1),
		.timer_input_two(p2), .internal_trigger_input(trg),
		.clock_from_rc_osc(rc), .update_event(upd),
		.timer_counter_value(ctr), .ch_output_reference(oref),
		.ch_capture_pulse(capp), .ch_filtered_level(filt));
	ccm_pins_model u_ccm_pins_model (.mclk(mclk), .pin_one(p1),
		.pin_two(p2), .trig(trg));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// Running capture totals; scenarios compare differences
	always @(posedge mclk) begin
		c0 <= c0 + int'(capp[0]);
		c1 <= c1 + int'(capp[1]);
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic test_done();
		if (bad_count == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : test_done
	// One APB transfer; request held until ready is seen high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge mclk);
		req.psel <= 1'b1;
		req.pwrite <= w;
		req.paddr <= a;
		req.pwdata <= d;
		@(posedge mclk);
		req.penable <= 1'b1;
		do @(posedge mclk); while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		er = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask : apb
	// Counter step, then the reference three cycles later
	task automatic setc(input logic [15:0] v, input logic e);
		@(posedge mclk);
		ctr <= v;
		repeat (3) @(posedge mclk);
		#1;
		chk(oref[0], e);
	endtask : setc
	task automatic cap(input int src, input int hi, input int e0, e1);
		int b0;
		int b1;
		b0 = c0;
		b1 = c1;
		u_ccm_pins_model.pulse(src, hi);
		chk(c0 - b0, e0);
		chk(c1 - b1, e1);
	endtask : cap
	initial begin
		int b0;
		logic seen;
		repeat (3) @(posedge mclk);
		reset_n <= 1'b1;
		apb(1'b0, MD, 32'h0);
		chk(rd, ccm_pkg::MODE_RESET);
		foreach (rows[i]) begin
			apb(1'b1, rows[i].a, rows[i].d);
			chk(er, rows[i].e);
			apb(1'b0, rows[i].a, 32'h0);
			chk(rd, rows[i].q);
			chk(er, rows[i].e);
		end
		// PWM 1 then PWM 2 on channel one against compare value 10
		apb(1'b1, MD, 32'h0000_0060);
		apb(1'b1, C1, 32'h0000_000a);
		setc(16'h0005, 1'b1);
		setc(16'h000c, 1'b0);
		apb(1'b1, MD, 32'h0000_0070);
		setc(16'h0005, 1'b0);
		setc(16'h000c, 1'b1);
		for (int o = 4; o < 6; o++) begin
			apb(1'b1, MD, o << 4 | o << 12);
			repeat (3) @(posedge mclk);
			#1;
			chk(oref, {2{o[0]}});
		end
		// Buffered write waits for the update event
		apb(1'b1, MD, 32'h0000_0068);
		setc(16'h000f, 1'b0);
		apb(1'b1, C1, 32'h0000_0014);
		setc(16'h000f, 1'b0);
		@(posedge mclk);
		upd <= 1'b1;
		@(posedge mclk);
		upd <= 1'b0;
		setc(16'h000f, 1'b1);
		// Fast enable: trigger edge acts as a match within 4 cycles
		apb(1'b1, MD, 32'h0000_0064);
		setc(16'h000f, 1'b1);
		seen = 1'b0;
		fork
			u_ccm_pins_model.pulse(2, 40);
			repeat (4) begin
				@(posedge mclk);
				#1;
				seen |= (oref[0] === 1'b0);
			end
		join
		chk(seen, 1'b1);
		for (int s = 1; s < 4; s++) begin
			apb(1'b1, MD, s | s << 8);
			for (int p = 0; p < 3; p++) begin
				cap(p, 40, p == s - 1, p == (s == 3 ? 2 : 2 - s));
			end
		end
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, MD, 1 | k << 2);
			b0 = c0;
			repeat (8) u_ccm_pins_model.pulse(0, 40);
			chk(c0 - b0, 8 >> k);
		end
		apb(1'b1, MD, 32'h0000_0021);
		cap(0, 40, 0, 0);
		cap(0, 80, 1, 0);
		rc <= 1'b1;
		cap(0, 80, 0, 0);
		apb(1'b1, MD, 32'h0000_0001);
		cap(0, 40, 1, 0);
		rc <= 1'b0;
		apb(1'b1, MD, 32'h0000_00f1);
		cap(0, 1500, 0, 0);
		cap(0, 3000, 1, 0);
		// Slower filter rates on both channels at once, both fed from pin one
		apb(1'b1, MD, 32'h0000_9261);
		cap(0, 200, 0, 0);
		cap(0, 400, 1, 0);
		cap(0, 700, 1, 1);
		apb(1'b1, MD, 32'h0000_c2a1);
		cap(0, 500, 0, 0);
		cap(0, 900, 1, 0);
		// Filtered level looked at while the pin is still high
		apb(1'b1, MD, 32'h0000_0201);
		fork
			cap(0, 80, 1, 1);
			begin
				repeat (40) @(posedge mclk);
				#1;
				chk(filt, 2'b11);
			end
		join
		// Capture readback, then sticky flags and their clearing
		apb(1'b0, C1, 32'h0);
		chk(rd, 32'h0000_000f);
		apb(1'b0, ccm_pkg::STATUS_OFFSET, 32'h0);
		chk(rd, 32'h0000_0003);
		apb(1'b1, ccm_pkg::STATUS_OFFSET, 32'h0000_0003);
		apb(1'b0, ccm_pkg::STATUS_OFFSET, 32'h0);
		chk(rd, 32'h0000_0000);
		// Reset in mid-run drops a forced reference and the mode word
		apb(1'b1, MD, 32'h0000_0050);
		repeat (3) @(posedge mclk);
		#1;
		chk(oref[0], 1'b1);
		@(posedge mclk);
		reset_n <= 1'b0;
		#1;
		chk(oref, 2'b00);
		repeat (2) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (2) @(posedge mclk);
		#1;
		chk(oref, 2'b00);
		apb(1'b0, MD, 32'h0);
		chk(rd, ccm_pkg::MODE_RESET);
		test_done();
	end
	// Hang guard, well beyond the expected run length
	initial begin
		repeat (60000) @(posedge mclk);
		bad_count++;
		test_done();
	end
endmodule : capture_compare_channel_mode_tb_top
bind ccm_channel_mode ccm_channel_mode_assertions u_chk (.mclk(mclk),
	.reset_n(reset_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
	.ch_output_reference(ch_output_reference),
	.ch_capture_pulse(ch_capture_pulse),
	.ch_filtered_level(ch_filtered_level));
